// [core/scd_clock_ctrl.sv]
// Sample clock detection, duty-cycle stabilizer and flag-reset control registers
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "scd_regs.svh"

module scd_clock_ctrl
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SCD_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic clk_detect_pin,
  input wire logic setup_err_evt,
  input wire logic hold_err_evt,
  output scd_clk_ctl_t clk_ctl,
  output logic clk_locked,
  output logic setup_err_flag,
  output logic hold_err_flag
);

  scd_state_t s_q;
  scd_state_t s_d;
  logic frst;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    frst = s_q.sref_ctl[`SCD_SREF_FRST_BIT];

    // ****************************************
    // Register writes
    // ****************************************
    if (wr) begin
      unique case (addr)
        `SCD_OFF_DET_CTL: s_d.det_ctl = wdata;
        `SCD_OFF_DCS1: s_d.dcs1 = wdata;
        `SCD_OFF_DCS2: s_d.dcs2 = wdata;
        `SCD_OFF_DCS3: s_d.dcs3 = wdata;
        `SCD_OFF_SREF_CTL: s_d.sref_ctl = wdata & `SCD_WMASK_SREF_CTL;
        default: s_d.det_ctl = s_q.det_ctl;
      endcase
    end

    // ****************************************
    // Detector pin filter
    // ****************************************
    // Pin filter: a change counts once stages two and three agree
    s_d.det_sync = {s_q.det_sync[1:0], clk_detect_pin};
    if (s_q.det_sync[1] == s_q.det_sync[2]) begin
      s_d.det_seen = s_q.det_sync[2];
    end

    // ****************************************
    // Error flags
    // ****************************************
    // Flag reset is a hold, so it overrides any event in the same cycle
    if (frst) begin
      s_d.setup_err = 1'b0;
      s_d.hold_err = 1'b0;
    end else begin
      s_d.setup_err = s_q.setup_err | setup_err_evt;
      s_d.hold_err = s_q.hold_err | hold_err_evt;
    end

    // ****************************************
    // Read data
    // ****************************************
    s_d.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        `SCD_OFF_DET_CTL: s_d.rdata = s_q.det_ctl;
        `SCD_OFF_DET_STAT: s_d.rdata = {7'h00, s_q.det_seen};
        `SCD_OFF_DCS1: s_d.rdata = s_q.dcs1;
        `SCD_OFF_DCS2: s_d.rdata = s_q.dcs2;
        `SCD_OFF_DCS3: s_d.rdata = s_q.dcs3;
        `SCD_OFF_SREF_CTL: s_d.rdata = s_q.sref_ctl;
        `SCD_OFF_SREF_STAT: s_d.rdata = {6'h00, s_q.hold_err, s_q.setup_err};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // ****************************************
    // Control outputs
    // ****************************************
    // A stage left powered down stays bypassed even if its enable is set
    s_d.ctl_out.threshold = s_q.det_ctl[`SCD_THR_LSB +: 2];
    s_d.ctl_out.dcs1_power = s_q.dcs1[`SCD_STAB_PWR_BIT];
    s_d.ctl_out.dcs1_active = s_q.dcs1[`SCD_STAB_EN_BIT] & s_q.dcs1[`SCD_STAB_PWR_BIT];
    s_d.ctl_out.dcs2_power = s_q.dcs2[`SCD_STAB_PWR_BIT];
    s_d.ctl_out.dcs2_active = s_q.dcs2[`SCD_STAB_EN_BIT] & s_q.dcs2[`SCD_STAB_PWR_BIT];
    s_d.ctl_out.dcs3_active = (s_q.dcs3 == `SCD_DCS3_ON);
    s_d.ctl_out.dcs3_code = s_q.dcs3;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.det_ctl <= `SCD_RST_DET_CTL;
      s_q.dcs1 <= `SCD_RST_DCS1;
      s_q.dcs2 <= `SCD_RST_DCS2;
      s_q.dcs3 <= `SCD_RST_DCS3;
      s_q.sref_ctl <= `SCD_RST_SREF_CTL;
      s_q.ctl_out.threshold <= `SCD_THR_HIGH_RATE;
      s_q.ctl_out.dcs3_code <= `SCD_RST_DCS3;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign clk_ctl = s_q.ctl_out;
  assign clk_locked = s_q.det_seen;
  assign setup_err_flag = s_q.setup_err;
  assign hold_err_flag = s_q.hold_err;

  // ****************************************
  // Checks: register bus
  // ****************************************
  a_thr_follows_write: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `SCD_OFF_DET_CTL |-> ##2 clk_ctl.threshold == $past(wdata[`SCD_THR_LSB +: 2], 2))
    else $error("threshold output does not follow written field");

  a_status_readback: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `SCD_OFF_DET_STAT |=> rdata == {7'h00, $past(clk_locked)})
    else $error("clock status read does not match locked state");

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");

  a_thr_write_only: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `SCD_OFF_DET_CTL) |=> $stable(s_q.det_ctl))
    else $error("detection control changed without a write");

  a_sref_mask_held: assert property (@(posedge clk) disable iff (rst)
    (s_q.sref_ctl & ~`SCD_WMASK_SREF_CTL) == 8'h00)
    else $error("read-only bit of flag reset control set");

  // ****************************************
  // Checks: detector pin
  // ****************************************

  a_lock_needs_agree: assert property (@(posedge clk) disable iff (rst)
    $rose(clk_locked) |-> $past(s_q.det_sync[1]) && $past(s_q.det_sync[2]))
    else $error("lock rose without two agreeing samples");

  a_lock_fall_agree: assert property (@(posedge clk) disable iff (rst)
    $fell(clk_locked) |-> !$past(s_q.det_sync[1]) && !$past(s_q.det_sync[2]))
    else $error("lock fell without two agreeing samples");

  a_lock_hold_still: assert property (@(posedge clk) disable iff (rst)
    s_q.det_sync[1] != s_q.det_sync[2] |=> $stable(clk_locked))
    else $error("lock changed while filter stages disagree");

  // ****************************************
  // Checks: stabilizers
  // ****************************************

  a_dcs1_order: assert property (@(posedge clk) disable iff (rst)
    clk_ctl.dcs1_active |-> clk_ctl.dcs1_power)
    else $error("first stabilizer enabled while powered down");

  a_dcs2_order: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `SCD_OFF_DCS2 && wdata[1:0] == 2'h3 |-> ##2 clk_ctl.dcs2_active && clk_ctl.dcs2_power)
    else $error("second stabilizer not active after power and enable");

  a_dcs1_power_follows: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `SCD_OFF_DCS1 |-> ##2 clk_ctl.dcs1_power == $past(wdata[`SCD_STAB_PWR_BIT], 2))
    else $error("first stabilizer power does not follow write");

  a_dcs2_power_follows: assert property (@(posedge clk) disable iff (rst)
    wr && addr == `SCD_OFF_DCS2 |-> ##2 clk_ctl.dcs2_power == $past(wdata[`SCD_STAB_PWR_BIT], 2))
    else $error("second stabilizer power does not follow write");

  a_dcs1_write_only: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `SCD_OFF_DCS1) |=> $stable(s_q.dcs1))
    else $error("first stabilizer control changed without a write");

  a_dcs2_write_only: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == `SCD_OFF_DCS2) |=> $stable(s_q.dcs2))
    else $error("second stabilizer control changed without a write");

  a_dcs3_exact_code: assert property (@(posedge clk) disable iff (rst)
    clk_ctl.dcs3_active == (clk_ctl.dcs3_code == `SCD_DCS3_ON))
    else $error("third stabilizer state does not match its code");

  // ****************************************
  // Checks: error flags
  // ****************************************

  a_flags_held: assert property (@(posedge clk) disable iff (rst)
    s_q.sref_ctl[`SCD_SREF_FRST_BIT] |=> !setup_err_flag && !hold_err_flag)
    else $error("error flags set while held in reset");

  a_flag_sets: assert property (@(posedge clk) disable iff (rst)
    !s_q.sref_ctl[`SCD_SREF_FRST_BIT] && setup_err_evt |=> setup_err_flag)
    else $error("setup error event lost");

  a_hold_flag_sets: assert property (@(posedge clk) disable iff (rst)
    !s_q.sref_ctl[`SCD_SREF_FRST_BIT] && hold_err_evt |=> hold_err_flag)
    else $error("hold error event lost");

  a_setup_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    !s_q.sref_ctl[`SCD_SREF_FRST_BIT] && setup_err_flag |=> setup_err_flag)
    else $error("setup error flag cleared while flag reset off");

  a_hold_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    !s_q.sref_ctl[`SCD_SREF_FRST_BIT] && hold_err_flag |=> hold_err_flag)
    else $error("hold error flag cleared while flag reset off");

  a_flag_status_read: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `SCD_OFF_SREF_STAT |=> rdata == {6'h00, $past(hold_err_flag), $past(setup_err_flag)})
    else $error("flag status read does not match flags");

  // ****************************************
  // Checks: reset
  // ****************************************

  a_reset_outputs: assert property (@(posedge clk)
    rst |=> clk_ctl.threshold == `SCD_THR_HIGH_RATE && clk_ctl.dcs3_code == `SCD_RST_DCS3 && rdata == 8'h00)
    else $error("control outputs wrong after reset");

  a_reset_flags: assert property (@(posedge clk)
    rst |=> !clk_locked && !setup_err_flag && !hold_err_flag)
    else $error("status outputs not cleared by reset");

endmodule

// [include/scd_pkg.sv]
// Types shared by the sample clock control block
package scd_pkg;

  typedef struct packed {
    logic [1:0] threshold;
    logic dcs1_power;
    logic dcs1_active;
    logic dcs2_power;
    logic dcs2_active;
    logic dcs3_active;
    logic [7:0] dcs3_code;
  } scd_clk_ctl_t;

  typedef struct packed {
    logic [7:0] det_ctl;
    logic [7:0] dcs1;
    logic [7:0] dcs2;
    logic [7:0] dcs3;
    logic [7:0] sref_ctl;
    logic [2:0] det_sync;
    logic det_seen;
    logic setup_err;
    logic hold_err;
    logic [7:0] rdata;
    scd_clk_ctl_t ctl_out;
  } scd_state_t;

endpackage

// [include/scd_regs.svh]
// Register offsets, field positions, reset values and the rule summary for sample clock control
// Function
// - Threshold field: code 01 for 300 MSPS and above, 11 below; resets to 01.
// - Status bit 0 reads 1 when input clock detected and locked, else 0.
// - First stabilizer: bit 0 powers up, bit 1 enables; power up first.
// - Second stabilizer: same layout and same power-up-before-enable order.
// - Flag reset bit 6 at 1 holds setup and hold flags cleared; 0 runs normally.
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define SCD_ADDR_W 16
`define SCD_OFF_DET_CTL 16'h011a
`define SCD_OFF_DET_STAT 16'h011b
`define SCD_OFF_DCS1 16'h011c
`define SCD_OFF_DCS2 16'h011e
`define SCD_OFF_DCS3 16'h011f
`define SCD_OFF_SREF_CTL 16'h0120
`define SCD_OFF_SREF_STAT 16'h0128

// ****************************************
// Reset values and write masks
// ****************************************
`define SCD_RST_DET_CTL 8'h09
`define SCD_RST_DCS1 8'h08
`define SCD_RST_DCS2 8'h88
`define SCD_RST_DCS3 8'h84
`define SCD_RST_SREF_CTL 8'h00
`define SCD_WMASK_SREF_CTL 8'h5e

// ****************************************
// Fields and codes
// ****************************************
`define SCD_THR_LSB 3
`define SCD_THR_HIGH_RATE 2'h1
`define SCD_THR_LOW_RATE 2'h3
`define SCD_STAB_PWR_BIT 0
`define SCD_STAB_EN_BIT 1
`define SCD_DCS3_ON 8'h81
`define SCD_SREF_FRST_BIT 6

`endif

// [test/scd_clock_ctrl_test.sv]
// Self-checking bench for the sample clock control block
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module scd_clock_ctrl_test
  import scd_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0, sev = 1'b0, hev = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  scd_clk_ctl_t clk_ctl;
  logic lk, sf, hf, lk_e = 1'b0, s_e = 1'b0, h_e = 1'b0;
  int fails = 0, cmp_count = 0, seed = 17;
  // Writable registers only; anything else reads 0 unless computed
  int mdl[int] = '{32'h011a: 9, 32'h011c: 8, 32'h011e: 136, 32'h011f: 132, 32'h0120: 0};
  logic [15:0] al[8] = '{16'h011a, 16'h011b, 16'h011c, 16'h011e, 16'h011f, 16'h0120, 16'h0128, 16'h0130};
  logic [7:0] tv[4] = '{8'h19, 8'h09, 8'h00, 8'h00};
  logic [7:0] dv[4] = '{8'h09, 8'h0b, 8'h09, 8'h08};

  scd_clock_ctrl DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .clk_detect_pin(pin), .setup_err_evt(sev), .hold_err_evt(hev), .clk_ctl(clk_ctl), .clk_locked(lk),
    .setup_err_flag(sf), .hold_err_flag(hf));

  always #20 clk = ~clk;

  // ****************
  // Bus tasks
  // ****************
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Read-only and unmapped writes leave the model alone
    if (mdl.exists(a)) mdl[a] = (a == 16'h0120) ? (d & 8'h5e) : d;
  endtask

  task automatic rchk(input logic [15:0] a);
    logic [7:0] e;
    e = mdl.exists(a) ? mdl[a][7:0] : 8'h00;
    if (a == 16'h011b) e = {7'h00, lk_e};
    if (a == 16'h0128) e = {6'h00, h_e, s_e};
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (al[i]) rchk(al[i]);
    `CHK(clk_ctl.threshold, 2'h1)
    `CHK(clk_ctl, 15'h2084)
    tv[2] = {3'h0, 2'($random(seed)), 3'h1};
    tv[3] = {3'h0, 2'($random(seed)), 3'h1};
    foreach (tv[i]) begin
      wreg(16'h011a, tv[i]);
      @(posedge clk);
      #1 `CHK(clk_ctl.threshold, tv[i][4:3])
      rchk(16'h011a);
    end
    wreg(16'h011b, 8'($random(seed)));
    rchk(16'h011b);
    foreach (dv[i]) begin
      wreg(16'h011c, dv[i]);
      wreg(16'h011e, dv[i]);
      @(posedge clk);
      #1 `CHK({clk_ctl.dcs1_power, clk_ctl.dcs1_active}, {dv[i][0], dv[i][1] & dv[i][0]})
      `CHK({clk_ctl.dcs2_power, clk_ctl.dcs2_active}, {dv[i][0], dv[i][1] & dv[i][0]})
    end
    wreg(16'h011f, 8'h81);
    @(posedge clk);
    #1 `CHK({clk_ctl.dcs3_active, clk_ctl.dcs3_code}, 9'h181)
    // Detector output settles within four edges of the pin
    @(posedge clk);
    pin <= 1'b1;
    repeat (5) @(posedge clk);
    lk_e = 1'b1;
    #1 `CHK(lk, 1'b1)
    rchk(16'h011b);
    @(posedge clk);
    pin <= 1'b0;
    repeat (5) @(posedge clk);
    lk_e = 1'b0;
    rchk(16'h011b);
    @(posedge clk);
    sev <= 1'b1;
    hev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    hev <= 1'b0;
    {s_e, h_e} = 2'b11;
    #1 `CHK({sf, hf}, 2'b11)
    rchk(16'h0128);
    wreg(16'h0120, 8'hff);
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    {s_e, h_e} = 2'b00;
    #1 `CHK({sf, hf}, 2'b00)
    rchk(16'h0128);
    rchk(16'h0120);
    wreg(16'h0120, 8'h00);
    @(posedge clk);
    hev <= 1'b1;
    @(posedge clk);
    hev <= 1'b0;
    h_e = 1'b1;
    #1 `CHK({sf, hf}, 2'b01)
    rchk(16'h0128);
    conclude();
  end
endmodule
